// >>> verilog/dcc_pkg.sv
// Shared constants, types and register layout for the downconverter channel block
package dcc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [11:0] CTRL_IDX = 12'h350;
	localparam logic [11:0] INSEL_IDX = 12'h351;
	localparam logic [11:0] CHAIN_IDX = 12'h352;
	// Control register field positions
	localparam int MIX_BIT = 7;
	localparam int GAIN_BIT = 6;
	localparam int IF_LSB = 4;
	localparam int C2R_BIT = 3;
	localparam int DEC_LSB = 0;
	// Input select register field positions
	localparam int EXT_LSB = 4;
	localparam int QSEL_BIT = 2;
	localparam int ISEL_BIT = 0;
	// Reset values and writable bits
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] INSEL_RST = 8'h00;
	localparam logic [7:0] INSEL_WMASK = 8'hf5;
	// Primary code that hands over to the extended field
	localparam logic [2:0] DEC_EXT = 3'h7;
	// Datapath word width and buffer depth
	localparam int DATA_W = 16;
	localparam int FIFO_DEPTH = 8;
	// Filter stage bits of the chain mask
	localparam logic [5:0] HALFBAND_STAGE_ONE = 6'h01;
	localparam logic [5:0] HALFBAND_STAGE_TWO = 6'h02;
	localparam logic [5:0] HALFBAND_STAGE_THREE = 6'h04;
	localparam logic [5:0] HALFBAND_STAGE_FOUR = 6'h08;
	localparam logic [5:0] THIRD_BAND_STAGE = 6'h10;
	localparam logic [5:0] FIFTH_BAND_STAGE = 6'h20;
	// IF mode encodings
	typedef enum logic [1:0] {
		IF_VAR = 2'b00,
		IF_ZERO = 2'b01,
		IF_FS = 2'b10,
		IF_TEST = 2'b11
	} dcc_if_e;
	// Bus slave states
	typedef enum logic {
		APB_IDLE = 1'b0,
		APB_DONE = 1'b1
	} dcc_apb_e;
	// One I/Q sample pair
	typedef struct packed {
		logic signed [DATA_W-1:0] i;
		logic signed [DATA_W-1:0] q;
	} dcc_pair_s;
	// Active filter stages and complex decimation factor
	typedef struct packed {
		logic [5:0] stages;
		logic [5:0] factor;
	} dcc_chain_s;
endpackage

// >>> verilog/dcc_fifo.sv
// Sample buffer with registered read data and valid/ready on both sides
`timescale 1ns/1ns
module dcc_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Drain side
	input wire logic out_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	// Words held in memory
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);

	// Depth must be a power of two for wrapping pointers
	if (DEPTH < 2 || (1 << AW) != DEPTH)
	begin : g_bad_depth
		$error("dcc_fifo depth must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr; // Next slot to fill
	logic [AW-1:0] rd_ptr; // Next slot to drain
	logic push;
	logic pop;

	// Honest full and load of the output register
	assign in_ready = (level != (AW+1)'(DEPTH));
	assign push = in_valid && in_ready;
	assign pop = (level != '0) && (!out_valid || out_ready);

	// Storage writes
	always_ff @(posedge clock)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// Pointers and occupancy
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			level <= level + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Registered read data
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			out_valid <= 1'b0;
			out_data <= '0;
		end
		else if (pop)
		begin
			out_valid <= 1'b1;
			out_data <= mem[rd_ptr];
		end
		else if (out_ready)
			out_valid <= 1'b0;
	end
endmodule

// >>> verilog/dcc_mixer.sv
// Output gain and quarter-rate complex-to-real conversion stage
`timescale 1ns/1ns
module dcc_mixer (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Settings
	input wire logic gain,
	input wire logic c2r,
	// Decimated pair in
	input wire logic in_valid,
	input wire dcc_pkg::dcc_pair_s in_pair,
	// Processed pair out
	output logic out_valid,
	output dcc_pkg::dcc_pair_s out_pair
);
	logic [1:0] phase; // Quarter-rate rotation step
	dcc_pkg::dcc_pair_s next_pair;

	// Rotation by quarter of output rate, then optional doubling
	always_comb
	begin
		next_pair = in_pair;
		if (c2r)
		begin
			// Only the real lane survives
			unique case (phase)
				2'h0: next_pair.i = in_pair.i;
				2'h1: next_pair.i = -in_pair.q;
				2'h2: next_pair.i = -in_pair.i;
				2'h3: next_pair.i = in_pair.q;
			endcase
			next_pair.q = '0;
		end
		if (gain)
		begin
			next_pair.i = next_pair.i <<< 1;
			next_pair.q = next_pair.q <<< 1;
		end
	end

	// Output register and rotation phase
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			out_valid <= 1'b0;
			out_pair <= '0;
			phase <= 2'h0;
		end
		else
		begin
			out_valid <= in_valid;
			if (in_valid)
			begin
				out_pair <= next_pair;
				phase <= c2r ? phase + 2'h1 : 2'h0;
			end
		end
	end
endmodule

// >>> verilog/dcc_channel_config.sv
// Downconverter channel: register file, source select, decimation and output buffer
//
// Operation
// - Mixer bit: real single channel, or complex
// - Gain bit doubles output samples
// - IF mode field: variable, zero, rate, test
// - Complex-to-real bit keeps real lane only
// - Codes 011 and 000: one or two half-bands
// - Codes 001 and 010: three or four half-bands
// - Codes 100..110 append third-band stage
// - Code 111 uses extended decimation field
// - Extended field ignored unless code is 111
// - Extended 0: third-band plus four half-bands
// - Extended 2..4: fifth-band after half-bands
// - Source bits pick channel A or B
`timescale 1ns/1ns
module dcc_channel_config #(
	parameter int SAMPLE_W = 14,
	parameter int DEPTH = dcc_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [13:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Converter sample streams
	input wire logic in_valid,
	input wire logic signed [SAMPLE_W-1:0] chan_a,
	input wire logic signed [SAMPLE_W-1:0] chan_b,
	output logic in_ready,
	// Toward the output framer
	input wire logic out_ready,
	output logic out_valid,
	output dcc_pkg::dcc_pair_s out_pair,
	output logic out_q_valid
);
	localparam int FW = $bits(dcc_pkg::dcc_pair_s) + 1;
	localparam int LW = $clog2(DEPTH) + 1;

	// Samples must fit the datapath with a bit left for gain
	if (SAMPLE_W < 2 || SAMPLE_W >= dcc_pkg::DATA_W)
	begin : g_bad_width
		$error("dcc_channel_config sample width out of range");
	end
	// Buffer must cover samples still in the pipeline
	if (DEPTH < 8)
	begin : g_bad_depth
		$error("dcc_channel_config buffer depth too small");
	end

	// Byte address match for a register index
	function automatic logic reg_hit(input logic [13:0] addr, input logic [11:0] idx);
		reg_hit = (addr == {idx, 2'b00});
	endfunction

	// Filter chain for primary and extended codes
	function automatic dcc_pkg::dcc_chain_s chain_of(input logic [2:0] code,
		input logic [3:0] ext);
		logic [5:0] one; // First half-band stage alone
		logic [5:0] two; // First two half-band stages
		logic [5:0] three; // First three half-band stages
		logic [5:0] four; // All four half-band stages
		dcc_pkg::dcc_chain_s c;
		one = dcc_pkg::HALFBAND_STAGE_ONE;
		two = one | dcc_pkg::HALFBAND_STAGE_TWO;
		three = two | dcc_pkg::HALFBAND_STAGE_THREE;
		four = three | dcc_pkg::HALFBAND_STAGE_FOUR;
		unique case (code)
			3'h3: c = '{one, 6'h02};
			3'h0: c = '{two, 6'h04};
			3'h1: c = '{three, 6'h08};
			3'h2: c = '{four, 6'h10};
			3'h4: c = '{one | dcc_pkg::THIRD_BAND_STAGE, 6'h06};
			3'h5: c = '{two | dcc_pkg::THIRD_BAND_STAGE, 6'h0c};
			3'h6: c = '{three | dcc_pkg::THIRD_BAND_STAGE, 6'h18};
			3'h7:
			begin
				// Extended field only consulted here
				unique case (ext)
					4'h2: c = '{one | dcc_pkg::FIFTH_BAND_STAGE, 6'h0a};
					4'h3: c = '{two | dcc_pkg::FIFTH_BAND_STAGE, 6'h14};
					4'h4: c = '{three | dcc_pkg::FIFTH_BAND_STAGE, 6'h28};
					// Code 0, and undefined codes fall back to it
					default: c = '{four | dcc_pkg::THIRD_BAND_STAGE, 6'h30};
				endcase
			end
		endcase
		chain_of = c;
	endfunction

	// Register contents
	logic [7:0] ctrl; // Mixer, gain, IF, real-output and decimation code
	logic [7:0] insel; // Extended code and lane sources
	dcc_pkg::dcc_apb_e apb_state;
	logic [7:0] next_rdata;
	logic next_err;

	// Decoded settings
	logic mix_cplx;
	logic gain_on;
	dcc_pkg::dcc_if_e if_mode;
	logic c2r;
	dcc_pkg::dcc_chain_s chain;
	logic [5:0] dec_factor;
	logic bus_wr; // Write completing this cycle

	// Datapath
	logic take; // Sample accepted this cycle
	logic [5:0] dec_cnt;
	logic signed [dcc_pkg::DATA_W-1:0] ramp; // Test pattern
	logic signed [dcc_pkg::DATA_W-1:0] i_src;
	logic signed [dcc_pkg::DATA_W-1:0] q_src;
	dcc_pkg::dcc_pair_s keep_pair;
	logic keep_valid;
	dcc_pkg::dcc_pair_s mix_pair;
	logic mix_valid;
	logic [LW-1:0] fifo_level;
	logic [FW-1:0] fifo_out;

	// Field decode
	assign mix_cplx = ctrl[dcc_pkg::MIX_BIT];
	assign gain_on = ctrl[dcc_pkg::GAIN_BIT];
	assign if_mode = dcc_pkg::dcc_if_e'(ctrl[dcc_pkg::IF_LSB +: 2]);
	assign c2r = ctrl[dcc_pkg::C2R_BIT];
	assign chain = chain_of(ctrl[dcc_pkg::DEC_LSB +: 3], insel[dcc_pkg::EXT_LSB +: 4]);
	// Real output runs at half the complex decimation
	assign dec_factor = c2r ? (chain.factor >> 1) : chain.factor;
	assign bus_wr = psel && penable && pready && pwrite && !pslverr;
	assign take = in_valid && in_ready;

	// Read data and address check for the access in progress
	always_comb
	begin
		next_rdata = 8'h00;
		next_err = 1'b0;
		if (reg_hit(paddr, dcc_pkg::CTRL_IDX))
			next_rdata = ctrl;
		else if (reg_hit(paddr, dcc_pkg::INSEL_IDX))
			next_rdata = insel & dcc_pkg::INSEL_WMASK;
		else if (reg_hit(paddr, dcc_pkg::CHAIN_IDX))
			next_rdata = {2'b00, chain.stages};
		else
			next_err = 1'b1; // Unmapped address
		if (pwrite && reg_hit(paddr, dcc_pkg::CHAIN_IDX))
			next_err = 1'b1; // Status is read-only
	end

	// APB handshake: one wait state per access
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			apb_state <= dcc_pkg::APB_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			unique case (apb_state)
				dcc_pkg::APB_IDLE:
				begin
					// Answer on the cycle after the access phase opens
					if (psel && penable)
					begin
						apb_state <= dcc_pkg::APB_DONE;
						pready <= 1'b1;
						pslverr <= next_err;
						prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, next_rdata};
					end
				end
				dcc_pkg::APB_DONE:
				begin
					// Completion edge; drop the answer
					apb_state <= dcc_pkg::APB_IDLE;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
			endcase
		end
	end

	// Register writes at the completion edge
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctrl <= dcc_pkg::CTRL_RST;
			insel <= dcc_pkg::INSEL_RST;
		end
		else if (bus_wr)
		begin
			if (reg_hit(paddr, dcc_pkg::CTRL_IDX))
				ctrl <= pwdata[7:0];
			if (reg_hit(paddr, dcc_pkg::INSEL_IDX))
				insel <= pwdata[7:0] & dcc_pkg::INSEL_WMASK;
		end
	end

	// Lane sources; a real mixer feeds one channel to both lanes
	always_comb
	begin
		i_src = insel[dcc_pkg::ISEL_BIT] ? dcc_pkg::DATA_W'(chan_b)
			: dcc_pkg::DATA_W'(chan_a);
		if (mix_cplx)
			q_src = insel[dcc_pkg::QSEL_BIT] ? dcc_pkg::DATA_W'(chan_b)
				: dcc_pkg::DATA_W'(chan_a);
		else
			q_src = i_src;
	end

	// Test pattern advances per accepted sample
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			ramp <= '0;
		else if (take)
			ramp <= ramp + 1'b1;
	end

	// Decimation: keep one sample in every dec_factor
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dec_cnt <= 6'h00;
			keep_valid <= 1'b0;
			keep_pair <= '0;
		end
		else
		begin
			keep_valid <= 1'b0;
			if (bus_wr)
				dec_cnt <= 6'h00; // Restart phase on new settings
			else if (take)
			begin
				if (dec_cnt >= dec_factor - 6'h01)
				begin
					dec_cnt <= 6'h00;
					keep_valid <= 1'b1;
					// Test mode replaces the samples
					if (if_mode == dcc_pkg::IF_TEST)
					begin
						keep_pair.i <= ramp;
						keep_pair.q <= ~ramp;
					end
					else
					begin
						// Tuning oscillator lives outside this block
						keep_pair.i <= i_src;
						keep_pair.q <= q_src;
					end
				end
				else
					dec_cnt <= dec_cnt + 6'h01;
			end
		end
	end

	// Gain and real conversion
	dcc_mixer u_mixer (
		.clock(clock),
		.sys_rst(sys_rst),
		.gain(gain_on),
		.c2r(c2r),
		.in_valid(keep_valid),
		.in_pair(keep_pair),
		.out_valid(mix_valid),
		.out_pair(mix_pair)
	);

	// Back-pressure: leave room for the two pipeline stages in flight
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			in_ready <= 1'b0;
		else
			in_ready <= (fifo_level <= LW'(DEPTH - 4));
	end

	// Buffer toward the framer
	dcc_fifo #(
		.WIDTH(FW),
		.DEPTH(DEPTH)
	) u_fifo (
		.clock(clock),
		.sys_rst(sys_rst),
		.in_valid(mix_valid),
		.in_data({!c2r, mix_pair}),
		.in_ready(),
		.out_ready(out_ready),
		.out_valid(out_valid),
		.out_data(fifo_out),
		.level(fifo_level)
	);

	// Registered buffer output split into its fields
	assign out_q_valid = fifo_out[FW-1];
	assign out_pair = fifo_out[FW-2:0];
endmodule

// >>> tb/dcc_channel_config_asserts.sv
// Port-level checker for the downconverter channel block
`timescale 1ns/1ns
module dcc_channel_config_asserts (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [13:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Output stream
	input wire logic out_ready,
	input wire logic out_valid,
	input wire dcc_pkg::dcc_pair_s out_pair,
	input wire logic out_q_valid
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	apb_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered after one wait");
	apb_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	rsv_read_a: assert property (pready && !pwrite && paddr == 14'hd44 |->
		prdata[3] == 1'b0 && prdata[1] == 1'b0) else $error("reserved bit read as one");
	upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	bad_addr_a: assert property (pready && paddr == 14'hd4c |-> pslverr)
		else $error("unmapped access without error");
	good_addr_a: assert property (pready && paddr == 14'hd40 |-> !pslverr)
		else $error("control access flagged");
	real_q_a: assert property (out_valid && !out_q_valid |-> out_pair.q == 16'h0000)
		else $error("idle q lane not zero");
	out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_pair))
		else $error("output changed while held");
endmodule

// >>> tb/dcc_stream_model.sv
// Converter sample source and output framer model
`timescale 1ns/1ns
module dcc_stream_model (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Bench controls
	input wire logic [7:0] budget,
	input wire logic stall,
	// Sample side
	input wire logic in_ready,
	output logic in_valid,
	output logic signed [13:0] chan_a,
	output logic signed [13:0] chan_b,
	// Framer side
	output logic out_ready
);
	logic [7:0] sent; // Samples taken so far
	logic [2:0] tick; // Framer pacing
	// Count taken samples; cleared while idle
	always_ff @(posedge clock or posedge sys_rst)
		if (sys_rst)
			sent <= 8'h00;
		else if (budget == 8'h00)
			sent <= 8'h00;
		else if (in_valid && in_ready)
			sent <= sent + 8'h01;
	// Framer stalls one cycle in eight
	always_ff @(posedge clock or posedge sys_rst)
		if (sys_rst)
			tick <= 3'h0;
		else
			tick <= tick + 3'h1;
	// Offer next sample; lines scramble when idle
	assign in_valid = budget != 8'h00 && sent < budget;
	assign chan_a = in_valid ? 14'(7 * (sent + 1)) : ~14'(7 * sent);
	assign chan_b = in_valid ? 14'(-5 * (sent + 1)) : ~14'(-5 * sent);
	assign out_ready = !stall && tick != 3'h5;
endmodule

// >>> tb/dcc_channel_config_tb.sv
// Self-checking bench for the downconverter channel block
`timescale 1ns/1ns
module dcc_channel_config_tb;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [13:0] paddr = 14'h0000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic in_valid;
	logic signed [13:0] chan_a;
	logic signed [13:0] chan_b;
	logic in_ready;
	logic out_ready;
	logic out_valid;
	dcc_pkg::dcc_pair_s out_pair;
	logic out_q_valid;
	logic [7:0] budget = 8'h00; // Samples to feed
	logic stall = 1'b0; // Framer hold-off
	logic [31:0] seed = 32'h0000e898; // Random state
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	logic [32:0] notes[$]; // Expected {q valid, pair}
	// Control and input select settings
	logic [15:0] cfg[14] = '{16'h8304, 16'h4001, 16'h9104, 16'ha205, 16'h8400, 16'h8500,
		16'h8600, 16'h8704, 16'h8724, 16'h8734, 16'h8744, 16'h8b04, 16'hcc04, 16'h3300};
	always #4 clock = ~clock;
	dcc_channel_config dut (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .in_valid, .chan_a, .chan_b, .in_ready, .out_ready,
		.out_valid, .out_pair, .out_q_valid);
	dcc_stream_model src (.clock, .sys_rst, .budget, .stall, .in_ready, .in_valid, .chan_a,
		.chan_b, .out_ready);
	task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wrap_up();
		if (errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// One APB transfer, held until ready
	task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	// Sample n of channel A or B, widened
	function automatic logic [15:0] smp(input logic b, input int n);
		return b ? 16'(-5 * n) : 16'(7 * n);
	endfunction
	// Kept-sample spacing for a setting
	function automatic int fac(input logic [7:0] c, input logic [7:0] s);
		int f;
		case (c[2:0])
			3'h0: f = 4;
			3'h1: f = 8;
			3'h2: f = 16;
			3'h3: f = 2;
			3'h4: f = 6;
			3'h5: f = 12;
			3'h6: f = 24;
			default: f = s[7:4] == 4'h2 ? 10 : s[7:4] == 4'h3 ? 20 : s[7:4] == 4'h4 ? 40 : 48;
		endcase
		return c[3] ? f / 2 : f;
	endfunction
	// Active filter stages for a setting
	function automatic logic [5:0] stg(input logic [7:0] c, input logic [7:0] s);
		case (c[2:0])
			3'h0: return 6'h03;
			3'h1: return 6'h07;
			3'h2: return 6'h0f;
			3'h3: return 6'h01;
			3'h4: return 6'h11;
			3'h5: return 6'h13;
			3'h6: return 6'h17;
			default: return s[7:4] == 4'h2 ? 6'h21 : s[7:4] == 4'h3 ? 6'h23
				: s[7:4] == 4'h4 ? 6'h27 : 6'h1f;
		endcase
	endfunction
	// Take the oldest note for each output word
	always @(posedge clock)
		if (out_valid === 1'b1 && out_ready === 1'b1)
		begin
			if (notes.size() == 0)
				check("extra", 33'h1, 33'h0);
			else
				check("out", {out_q_valid, out_pair}, notes.pop_front());
		end
	// Hang guard
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			errors++;
			wrap_up();
		end
	end
	initial
	begin
		logic [31:0] r;
		logic e;
		logic [7:0] c;
		logic [7:0] s;
		logic [15:0] vi;
		logic [15:0] vq;
		int n;
		int k;
		int w;
		int tot; // Samples taken since reset
		tot = 0;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		apb(1'b0, 14'hd40, 32'h0, r, e);
		check("ctrl", {e, r}, 33'h0);
		apb(1'b0, 14'hd44, 32'h0, r, e);
		check("insel", {e, r}, 33'h0);
		apb(1'b1, 14'hd4c, 32'hff, r, e);
		check("unmapped write", {e, r}, {1'b1, 32'h0});
		apb(1'b0, 14'hd4c, 32'h0, r, e);
		check("unmapped", {e, r}, {1'b1, 32'h0});
		apb(1'b1, 14'hd48, 32'hff, r, e);
		check("status write", {e, r}, {1'b1, 32'h0});
		foreach (cfg[j])
		begin
			seed = xs(seed);
			c = cfg[j][15:8];
			// Random reserved bits, and random extended field unless code selects it
			s = cfg[j][7:0] | (seed[7:0] & 8'h0a) | (c[2:0] == 3'h7 ? 8'h00 : seed[15:8] & 8'hf0);
			apb(1'b1, 14'hd40, {24'h0, c}, r, e);
			apb(1'b1, 14'hd44, {24'h0, s}, r, e);
			apb(1'b0, 14'hd44, 32'h0, r, e);
			check("insel", {e, r}, {25'h0, s & 8'hf5});
			n = fac(c, s);
			k = c == 8'h8b ? 12 : 3;
			apb(1'b0, 14'hd48, 32'h0, r, e);
			check("stages", {e, r}, {27'h0, stg(c, s)});
			for (int i = 1; i <= k; i++)
			begin
				vi = smp(s[0], i * n) <<< c[6];
				vq = c[7] ? smp(s[2], i * n) <<< c[6] : vi;
				// Test mode: ramp of taken samples on I, its inverse on Q
				if (c[5:4] == 2'h3)
				begin
					vi = 16'(tot + i * n - 1) <<< c[6];
					vq = ~16'(tot + i * n - 1) <<< c[6];
				end
				if (c[3])
					notes.push_back({1'b0, i % 4 == 1 ? vi : i % 4 == 2 ? -vq : i % 4 == 3 ? -vi : vq, 16'h0});
				else
					notes.push_back({1'b1, vi, vq});
			end
			stall <= c == 8'h8b;
			budget <= 8'(k * n);
			tot += k * n;
			w = 0;
			// Hold the framer off until the buffer refuses
			while (c == 8'h8b && in_ready !== 1'b0 && w < 100)
			begin
				w++;
				@(posedge clock);
			end
			if (c == 8'h8b)
				check("refuse", {32'h0, in_ready}, 33'h0);
			stall <= 1'b0;
			w = 0;
			while (notes.size() != 0 && w < 3000)
			begin
				w++;
				@(posedge clock);
			end
			budget <= 8'h00;
			check("drained", {32'h0, notes.size() == 0}, 33'h1);
		end
		wrap_up();
	end
endmodule
bind dcc_channel_config dcc_channel_config_asserts chk (.clock, .sys_rst, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .out_ready, .out_valid, .out_pair, .out_q_valid);
